// ---- include/dsrb_pkg.sv ----
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package dsrb_pkg;

    // -------------------------------------------------------------------------
    // Register indices; byte address is four times the index.
    // -------------------------------------------------------------------------
    localparam logic [5:0] IDX_TILE_CELL_OSC = 6'h07;
    localparam logic [5:0] IDX_TILE_WIRE_OSC = 6'h08;
    localparam logic [5:0] IDX_PERIPH_CELL_OSC = 6'h09;
    localparam logic [5:0] IDX_PERIPH_WIRE_OSC = 6'h0A;
    localparam logic [5:0] IDX_MEMORY_SIZE = 6'h0C;
    localparam logic [5:0] IDX_STATUS_WORD = 6'h10;
    localparam logic [5:0] IDX_PROGRAM_COUNTER = 6'h11;
    localparam logic [5:0] IDX_STACK_POINTER = 6'h12;
    localparam logic [5:0] IDX_FETCH_THREAD = 6'h13;
    localparam logic [5:0] IDX_FETCH_REGISTER = 6'h14;
    localparam logic [5:0] IDX_HALT_CAUSE = 6'h15;
    localparam logic [5:0] IDX_HALT_CAUSE_DATA = 6'h16;
    localparam logic [5:0] IDX_THREAD_HALT_MASK = 6'h18;
    localparam logic [5:0] IDX_SCRATCH_BASE = 6'h20;
    localparam logic [5:0] IDX_BREAK_BASE = 6'h30;
    localparam logic [5:0] IDX_BREAK_ENABLE = 6'h34;
    localparam logic [5:0] IDX_EVENT_STATUS = 6'h38;
    localparam logic [5:0] IDX_EVENT_MASK = 6'h39;

    // -------------------------------------------------------------------------
    // Field layouts and values.
    // -------------------------------------------------------------------------
    localparam int OSC_COUNT_W = 16;
    localparam int OSC_NUM = 4;
    localparam logic [31:0] MEMORY_SIZE_BYTES = 32'h0004_0000;
    localparam logic [31:0] MEMORY_SIZE_MASK = 32'hFFFF_FFFC;
    localparam logic [10:0] STATUS_CAPTURE_MASK = 11'h7DF;
    localparam logic [10:0] STATUS_WRITE_MASK = 11'h6DF;
    localparam int STATUS_DUAL_ISSUE_BIT = 8;
    localparam int CAUSE_POINT_LSB = 16;
    localparam int CAUSE_THREAD_LSB = 8;
    localparam logic [2:0] CAUSE_NONE = 3'h0;
    localparam logic [2:0] CAUSE_HOST = 3'h1;
    localparam logic [2:0] CAUSE_CALL = 3'h2;
    localparam logic [2:0] CAUSE_CODE_BREAK = 3'h3;
    localparam logic [2:0] CAUSE_DATA_WATCH = 3'h4;
    localparam logic [2:0] CAUSE_RESOURCE_WATCH = 3'h5;
    localparam int SCRATCH_NUM = 8;
    localparam int BREAK_NUM = 4;
    localparam int EVENT_ENTRY_BIT = 0;
    localparam int EVENT_CAUSE_BIT = 1;
    localparam int EVENT_BREAK_BIT = 2;
    localparam int OSC_STOP_CYCLES = 10;

endpackage : dsrb_pkg

// ---- rtl/dsrb_top.sv ----
// Chosen here: register access over APB.
`timescale 1ns/1ps
module dsrb_top (
    // Clock, reset and clock enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // Ring oscillator edges, asynchronous to pclk
    input wire logic [dsrb_pkg::OSC_NUM-1:0] osc_clk_in,
    // Debug handler entry
    input wire logic dbg_enter,
    input wire logic [31:0] saved_status_word,
    input wire logic [31:0] saved_program_counter,
    input wire logic [31:0] saved_stack_pointer,
    // Debug interrupt report
    input wire logic dbg_event,
    input wire logic [2:0] dbg_cause,
    input wire logic [7:0] dbg_thread,
    input wire logic [3:0] dbg_point_hits,
    input wire logic [31:0] dbg_data,
    // Remote register fetch operands
    output logic [7:0] fetch_thread,
    output logic [4:0] fetch_register,
    // Thread halting
    input wire logic in_debug_mode,
    output logic [7:0] thread_halt,
    // Code breakpoint compare
    input wire logic pc_valid,
    input wire logic [31:0] thread_pc,
    output logic [dsrb_pkg::BREAK_NUM-1:0] ibreak_hit,
    // Scratch port of the tile configuration space
    input wire logic cfg_scratch_we,
    input wire logic [2:0] cfg_scratch_idx,
    input wire logic [31:0] cfg_scratch_wdata,
    output logic [31:0] cfg_scratch_rdata,
    // Interrupt
    output logic irq
);
    import dsrb_pkg::*;

    //--------------------------------------------------------------------------
    // APB decode
    //--------------------------------------------------------------------------
    logic rd_ok_q;
    logic [31:0] prdata_q;
    logic pslverr_q;
    wire [5:0] idx = paddr[7:2];
    wire apb_done = psel && penable && pready;
    wire wr_en = apb_done && pwrite;
    wire is_osc = (idx >= IDX_TILE_CELL_OSC) && (idx <= IDX_PERIPH_WIRE_OSC);
    wire is_scratch = (idx >= IDX_SCRATCH_BASE) && (idx < IDX_SCRATCH_BASE + 6'h08);
    wire is_break = (idx >= IDX_BREAK_BASE) && (idx < IDX_BREAK_BASE + 6'h04);
    wire [1:0] osc_sel = 2'(idx - IDX_TILE_CELL_OSC);
    wire [2:0] scr_sel = 3'(idx - IDX_SCRATCH_BASE);
    wire [1:0] brk_sel = 2'(idx - IDX_BREAK_BASE);
    wire mapped = is_osc || is_scratch || is_break || (idx == IDX_MEMORY_SIZE)
        || ((idx >= IDX_STATUS_WORD) && (idx <= IDX_HALT_CAUSE_DATA))
        || (idx == IDX_THREAD_HALT_MASK) || (idx == IDX_BREAK_ENABLE)
        || (idx == IDX_EVENT_STATUS) || (idx == IDX_EVENT_MASK);

    // Read data is taken one cycle ahead, so the access phase answers at once.
    assign pready = psel && penable && clk_en && rd_ok_q;
    assign prdata = prdata_q;
    assign pslverr = pready && pslverr_q;

    //--------------------------------------------------------------------------
    // Ring oscillator counters
    //--------------------------------------------------------------------------
    logic [OSC_NUM-1:0] osc_s1_q, osc_s2_q, osc_s3_q, osc_lvl_q;
    // Counts power up at zero and no reset touches them afterwards.
    logic [OSC_COUNT_W-1:0] osc_cnt_q [OSC_NUM] = '{default: '0};
    wire [OSC_NUM-1:0] osc_agree = ~(osc_s2_q ^ osc_s3_q);
    wire [OSC_NUM-1:0] osc_rise = osc_agree & osc_s3_q & ~osc_lvl_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_s1_q <= '0;
            osc_s2_q <= '0;
            osc_s3_q <= '0;
            osc_lvl_q <= '0;
        end else if (clk_en) begin
            osc_s1_q <= osc_clk_in;
            osc_s2_q <= osc_s1_q;
            osc_s3_q <= osc_s2_q;
            osc_lvl_q <= (osc_agree & osc_s3_q) | (~osc_agree & osc_lvl_q);
        end
    end

    // The counts have no reset so they live through a system reset.
    always_ff @(posedge pclk) begin
        for (int i = 0; i < OSC_NUM; i++) begin
            if (clk_en && osc_rise[i]) begin
                osc_cnt_q[i] <= osc_cnt_q[i] + 16'h0001;
            end
        end
    end

    //--------------------------------------------------------------------------
    // Captured thread state and debug cause
    //--------------------------------------------------------------------------
    logic [10:0] status_q;
    logic [31:0] pc_q, sp_q, cause_data_q;
    logic [7:0] fetch_thread_q, halt_mask_q, cause_thread_q;
    logic [4:0] fetch_reg_q;
    logic [2:0] cause_q;
    logic [1:0] cause_point_q;

    function automatic logic [1:0] lowest_hit(input logic [3:0] hits);
        logic [1:0] n;
        n = 2'h0;
        for (int i = 3; i >= 0; i--) begin
            if (hits[i]) begin
                n = 2'(i);
            end
        end
        return n;
    endfunction : lowest_hit

    wire host_or_call = (dbg_cause == CAUSE_HOST) || (dbg_cause == CAUSE_CALL);
    wire watch_cause = (dbg_cause == CAUSE_DATA_WATCH) || (dbg_cause == CAUSE_RESOURCE_WATCH);
    wire [1:0] point_d = host_or_call ? 2'h0 : lowest_hit(dbg_point_hits);
    wire [7:0] thread_d = (dbg_cause == CAUSE_HOST) ? 8'h00 : dbg_thread;
    wire [10:0] status_wr = (status_q & ~STATUS_WRITE_MASK)
        | (pwdata[10:0] & STATUS_WRITE_MASK);

    // Hardware capture takes priority over a software write in the same cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q <= '0;
            pc_q <= '0;
            sp_q <= '0;
        end else if (clk_en && dbg_enter) begin
            status_q <= saved_status_word[10:0] & STATUS_CAPTURE_MASK;
            pc_q <= saved_program_counter;
            sp_q <= saved_stack_pointer;
        end else if (wr_en) begin
            status_q <= (idx == IDX_STATUS_WORD) ? status_wr : status_q;
            pc_q <= (idx == IDX_PROGRAM_COUNTER) ? pwdata : pc_q;
            sp_q <= (idx == IDX_STACK_POINTER) ? pwdata : sp_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cause_q <= CAUSE_NONE;
            cause_point_q <= '0;
            cause_thread_q <= '0;
            cause_data_q <= '0;
        end else if (clk_en && dbg_event) begin
            cause_q <= dbg_cause;
            cause_point_q <= point_d;
            cause_thread_q <= thread_d;
            cause_data_q <= watch_cause ? dbg_data : cause_data_q;
        end else if (wr_en && (idx == IDX_HALT_CAUSE)) begin
            cause_q <= pwdata[2:0];
            cause_point_q <= pwdata[17:16];
            cause_thread_q <= pwdata[15:8];
        end else if (wr_en && (idx == IDX_HALT_CAUSE_DATA)) begin
            cause_data_q <= pwdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fetch_thread_q <= '0;
            fetch_reg_q <= '0;
            halt_mask_q <= '0;
        end else if (wr_en) begin
            fetch_thread_q <= (idx == IDX_FETCH_THREAD) ? pwdata[7:0] : fetch_thread_q;
            fetch_reg_q <= (idx == IDX_FETCH_REGISTER) ? pwdata[4:0] : fetch_reg_q;
            halt_mask_q <= (idx == IDX_THREAD_HALT_MASK) ? pwdata[7:0] : halt_mask_q;
        end
    end

    assign fetch_thread = fetch_thread_q;
    assign fetch_register = fetch_reg_q;

    // A halted thread is held whenever the core is not in debug mode.
    logic [7:0] thread_halt_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            thread_halt_q <= '0;
        end else if (clk_en) begin
            thread_halt_q <= in_debug_mode ? 8'h00 : halt_mask_q;
        end
    end
    assign thread_halt = thread_halt_q;

    //--------------------------------------------------------------------------
    // Scratch words
    //--------------------------------------------------------------------------
    // The APB write wins if both ports hit the same word in one cycle.
    logic [31:0] scratch_q [SCRATCH_NUM];
    logic [31:0] cfg_rdata_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < SCRATCH_NUM; i++) begin
                scratch_q[i] <= '0;
            end
            cfg_rdata_q <= '0;
        end else if (clk_en) begin
            if (cfg_scratch_we) begin
                scratch_q[cfg_scratch_idx] <= cfg_scratch_wdata;
            end
            if (wr_en && is_scratch) begin
                scratch_q[scr_sel] <= pwdata;
            end
            cfg_rdata_q <= scratch_q[cfg_scratch_idx];
        end
    end
    assign cfg_scratch_rdata = cfg_rdata_q;

    //--------------------------------------------------------------------------
    // Code breakpoints
    //--------------------------------------------------------------------------
    logic [31:0] brk_addr_q [BREAK_NUM];
    logic [BREAK_NUM-1:0] brk_en_q, ibreak_hit_q;
    logic [BREAK_NUM-1:0] brk_match;
    for (genvar g = 0; g < BREAK_NUM; g++) begin : g_brk
        assign brk_match[g] = pc_valid && brk_en_q[g] && (thread_pc == brk_addr_q[g]);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < BREAK_NUM; i++) begin
                brk_addr_q[i] <= '0;
            end
            brk_en_q <= '0;
            ibreak_hit_q <= '0;
        end else if (clk_en) begin
            ibreak_hit_q <= brk_match;
            if (wr_en && is_break) begin
                brk_addr_q[brk_sel] <= pwdata;
            end
            if (wr_en && (idx == IDX_BREAK_ENABLE)) begin
                brk_en_q <= pwdata[3:0];
            end
        end
    end
    assign ibreak_hit = ibreak_hit_q;

    //--------------------------------------------------------------------------
    // Event status and interrupt
    //--------------------------------------------------------------------------
    logic [2:0] ev_status_q, ev_mask_q;
    wire [2:0] ev_set = {|brk_match, dbg_event, dbg_enter};
    wire [2:0] ev_clr = (wr_en && (idx == IDX_EVENT_STATUS)) ? pwdata[2:0] : 3'h0;

    // A new event in the clearing cycle keeps its bit set.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ev_status_q <= '0;
            ev_mask_q <= '0;
        end else if (clk_en) begin
            ev_status_q <= (ev_status_q & ~ev_clr) | ev_set;
            if (wr_en && (idx == IDX_EVENT_MASK)) begin
                ev_mask_q <= pwdata[2:0];
            end
        end
    end
    assign irq = |(ev_status_q & ev_mask_q);

    //--------------------------------------------------------------------------
    // Read path
    //--------------------------------------------------------------------------
    wire [31:0] rd_word =
        is_osc ? {16'h0000, osc_cnt_q[osc_sel]} :
        (idx == IDX_MEMORY_SIZE) ? (MEMORY_SIZE_BYTES & MEMORY_SIZE_MASK) :
        (idx == IDX_STATUS_WORD) ? {21'h000000, status_q} :
        (idx == IDX_PROGRAM_COUNTER) ? pc_q :
        (idx == IDX_STACK_POINTER) ? sp_q :
        (idx == IDX_FETCH_THREAD) ? {24'h000000, fetch_thread_q} :
        (idx == IDX_FETCH_REGISTER) ? {27'h0000000, fetch_reg_q} :
        (idx == IDX_HALT_CAUSE) ? {14'h0000, cause_point_q, cause_thread_q, 5'h00, cause_q} :
        (idx == IDX_HALT_CAUSE_DATA) ? cause_data_q :
        (idx == IDX_THREAD_HALT_MASK) ? {24'h000000, halt_mask_q} :
        is_scratch ? scratch_q[scr_sel] :
        is_break ? brk_addr_q[brk_sel] :
        (idx == IDX_BREAK_ENABLE) ? {28'h0000000, brk_en_q} :
        (idx == IDX_EVENT_STATUS) ? {29'h00000000, ev_status_q} :
        (idx == IDX_EVENT_MASK) ? {29'h00000000, ev_mask_q} : 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_ok_q <= 1'b0;
            prdata_q <= '0;
            pslverr_q <= 1'b0;
        end else if (clk_en) begin
            rd_ok_q <= psel && !apb_done;
            if (psel && !apb_done) begin
                prdata_q <= rd_word;
                pslverr_q <= !mapped;
            end
        end
    end

    //--------------------------------------------------------------------------
    // Assertions
    //--------------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    wire rd_setup = psel && !penable && !pwrite && clk_en && !apb_done;

    sequence s_entry;
        clk_en && dbg_enter;
    endsequence

    sequence s_event;
        clk_en && dbg_event;
    endsequence

    chk_osc_hold: assert property (clk_en && !osc_rise[0] |=> $stable(osc_cnt_q[0]))
        else $error("oscillator count moved without an edge");

    chk_osc_order: assert property (rd_setup && idx == IDX_TILE_WIRE_OSC
        |=> prdata_q == {16'h0000, $past(osc_cnt_q[1])})
        else $error("tile wire count read wrong");

    chk_mem_size: assert property (rd_setup && idx == IDX_MEMORY_SIZE
        |=> prdata_q[1:0] == 2'h0 && prdata_q == (MEMORY_SIZE_BYTES & MEMORY_SIZE_MASK))
        else $error("memory size read wrong");

    chk_status_capture: assert property (s_entry
        |=> status_q == ($past(saved_status_word[10:0]) & STATUS_CAPTURE_MASK))
        else $error("status word not captured");

    chk_pc_sp_capture: assert property (s_entry
        |=> pc_q == $past(saved_program_counter) && sp_q == $past(saved_stack_pointer))
        else $error("program counter or stack pointer not captured");

    chk_fetch_operands: assert property (wr_en && idx == IDX_FETCH_THREAD
        |=> fetch_thread == $past(pwdata[7:0]))
        else $error("fetch thread operand not loaded");

    chk_cause_record: assert property (s_event
        |=> cause_q == $past(dbg_cause) && cause_point_q == $past(point_d)
            && cause_thread_q == $past(thread_d))
        else $error("debug cause not recorded");

    chk_host_zero: assert property (s_event and (dbg_cause == CAUSE_HOST)
        |=> cause_thread_q == 8'h00 && cause_point_q == 2'h0)
        else $error("host cause left thread or point set");

    chk_data_load: assert property (s_event and watch_cause
        |=> cause_data_q == $past(dbg_data))
        else $error("cause data not loaded");

    chk_halt_gate: assert property (clk_en && !in_debug_mode
        |=> thread_halt == $past(halt_mask_q))
        else $error("halted thread released outside debug mode");

    chk_scratch_share: assert property (wr_en && is_scratch ##1 clk_en && !cfg_scratch_we
        && cfg_scratch_idx == $past(scr_sel) && !(wr_en && is_scratch)
        |=> cfg_scratch_rdata == $past(pwdata, 2))
        else $error("scratch word not shared");

    chk_break_hit: assert property (clk_en && brk_match[0] |=> ibreak_hit[0]
        && ev_status_q[EVENT_BREAK_BIT])
        else $error("code breakpoint missed");

    chk_issue_bit_ro: assert property (wr_en && idx == IDX_STATUS_WORD && !dbg_enter
        |=> status_q[STATUS_DUAL_ISSUE_BIT] == $past(status_q[STATUS_DUAL_ISSUE_BIT]))
        else $error("issue mode bit written");

    chk_reserved_zero: assert property (rd_setup && idx == IDX_FETCH_REGISTER
        |=> prdata_q[31:5] == 27'h0000000)
        else $error("reserved bits read nonzero");

endmodule : dsrb_top

// ---- verif/dsrb_core_model.sv ----
`timescale 1ns/1ps
module dsrb_core_model (
    // Clock
    input wire logic pclk,
    // Oscillators and handler entry
    output logic [3:0] osc_clk_in,
    output logic dbg_enter,
    output logic [31:0] saved_status_word,
    output logic [31:0] saved_program_counter,
    output logic [31:0] saved_stack_pointer,
    // Debug interrupt report
    output logic dbg_event,
    output logic [2:0] dbg_cause,
    output logic [7:0] dbg_thread,
    output logic [3:0] dbg_point_hits,
    output logic [31:0] dbg_data
);
    initial begin
        {osc_clk_in, dbg_enter, dbg_event, dbg_cause, dbg_thread, dbg_point_hits} = '0;
        {saved_status_word, saved_program_counter, saved_stack_pointer, dbg_data} = '0;
    end
    // Each level is held four cycles so that the three-flop synchroniser settles.
    task automatic run_osc(input int k, input int n);
        repeat (2 * n) begin
            @(posedge pclk);
            osc_clk_in[k] <= ~osc_clk_in[k];
            repeat (3) @(posedge pclk);
        end
    endtask : run_osc
    task automatic enter(input logic [31:0] s, input logic [31:0] p, input logic [31:0] q);
        @(posedge pclk);
        {dbg_enter, saved_status_word, saved_program_counter, saved_stack_pointer} <= {1'b1, s, p, q};
        @(posedge pclk);
        // The saved values are gone after the pulse, so stale data is scrambled.
        {dbg_enter, saved_status_word, saved_program_counter, saved_stack_pointer} <= {1'b0, ~s, ~p, ~q};
    endtask : enter
    task automatic report(input logic [2:0] c, input logic [7:0] t, input logic [3:0] h,
                          input logic [31:0] d);
        @(posedge pclk);
        {dbg_event, dbg_cause, dbg_thread, dbg_point_hits, dbg_data} <= {1'b1, c, t, h, d};
        @(posedge pclk);
        {dbg_event, dbg_cause, dbg_thread, dbg_point_hits, dbg_data} <= {1'b0, ~c, ~t, ~h, ~d};
    endtask : report
endmodule : dsrb_core_model

// ---- verif/testbench.sv ----
`timescale 1ns/1ps
module testbench;
    import dsrb_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, in_debug_mode, pc_valid, cfg_scratch_we, er, clk_en;
    logic [7:0] paddr;
    logic [2:0] cfg_scratch_idx;
    logic [31:0] pwdata, thread_pc, cfg_scratch_wdata, rd, v;
    logic [31:0] mdl [64];
    logic [31:0] c0 [4];
    wire logic pready, pslverr, irq, dbg_enter, dbg_event;
    wire logic [31:0] prdata, saved_status_word, saved_program_counter, saved_stack_pointer;
    wire logic [31:0] dbg_data, cfg_scratch_rdata;
    wire logic [3:0] osc_clk_in, dbg_point_hits, ibreak_hit;
    wire logic [2:0] dbg_cause;
    wire logic [7:0] dbg_thread, fetch_thread, thread_halt;
    wire logic [4:0] fetch_register;
    int failures, samples_checked, p;
    int seed = 32'h06990D62;
    localparam logic [5:0] RW_SET [16] = '{6'h0C, 6'h10, 6'h11, 6'h12, 6'h13, 6'h14, 6'h15,
        6'h16, 6'h18, 6'h20, 6'h27, 6'h30, 6'h33, 6'h34, 6'h38, 6'h39};
    dsrb_top dut (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pready, .prdata, .pslverr, .osc_clk_in, .dbg_enter, .saved_status_word,
        .saved_program_counter, .saved_stack_pointer, .dbg_event, .dbg_cause, .dbg_thread,
        .dbg_point_hits, .dbg_data, .fetch_thread, .fetch_register, .in_debug_mode,
        .thread_halt, .pc_valid, .thread_pc, .ibreak_hit, .cfg_scratch_we, .cfg_scratch_idx,
        .cfg_scratch_wdata, .cfg_scratch_rdata, .irq);
    dsrb_core_model core (.pclk, .osc_clk_in, .dbg_enter, .saved_status_word,
        .saved_program_counter, .saved_stack_pointer, .dbg_event, .dbg_cause, .dbg_thread,
        .dbg_point_hits, .dbg_data);
    // -------------------------------------------------------------------------
    // Bus cycles, model and comparison.
    // -------------------------------------------------------------------------
    function automatic logic [31:0] wm(input logic [5:0] i);
        case (i)
            IDX_STATUS_WORD: return {21'h0, STATUS_WRITE_MASK};
            IDX_FETCH_THREAD, IDX_THREAD_HALT_MASK: return 32'h0000_00FF;
            IDX_FETCH_REGISTER: return 32'h0000_001F;
            IDX_HALT_CAUSE: return 32'h0003_FF07;
            IDX_BREAK_ENABLE: return 32'h0000_000F;
            IDX_EVENT_MASK: return 32'h0000_0007;
            IDX_PROGRAM_COUNTER, IDX_STACK_POINTER, IDX_HALT_CAUSE_DATA: return 32'hFFFF_FFFF;
            default: return (i inside {[6'h20:6'h27], [6'h30:6'h33]}) ? 32'hFFFF_FFFF : 32'h0;
        endcase
    endfunction : wm
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // The answer is taken at the rising edge at which pready is seen high.
    task automatic apb(input logic wr, input logic [5:0] i, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, i, 2'b00, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        {rd, er} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
    endtask : apb
    task automatic w(input logic [5:0] i, input logic [31:0] d);
        apb(1'b1, i, d);
        chk({31'h0, er}, 32'h0);
        if (i == IDX_EVENT_STATUS) mdl[i] &= ~d;
        else mdl[i] = (mdl[i] & ~wm(i)) | (d & wm(i));
    endtask : w
    task automatic r(input logic [5:0] i);
        apb(1'b0, i, 32'h0);
        chk(rd, mdl[i]);
    endtask : r
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : wrap_up
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        failures++;
        wrap_up();
    end
    // -------------------------------------------------------------------------
    // Scenarios.
    // -------------------------------------------------------------------------
    initial begin
        {psel, penable, pwrite, paddr, pwdata, in_debug_mode, pc_valid, thread_pc} = '0;
        {cfg_scratch_we, cfg_scratch_idx, cfg_scratch_wdata, presetn} = '0;
        clk_en = 1'b1;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            for (int j = 0; j < 4; j++) begin
                apb(1'b0, 6'(IDX_TILE_CELL_OSC + j), 32'h0);
                c0[j] = rd;
            end
            core.run_osc(k, k + 2);
            repeat (12) @(posedge pclk);
            for (int j = 0; j < 4; j++) begin
                apb(1'b0, 6'(IDX_TILE_CELL_OSC + j), 32'h0);
                chk(rd & 32'hFFFF_0000, 32'h0);
                if (!$isunknown(c0[j])) chk((rd - c0[j]) & 32'hFFFF, 32'((j == k) ? k + 2 : 0));
            end
        end
        v = rd;
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, IDX_PERIPH_WIRE_OSC, 32'h0);
        chk(rd, v);
        foreach (mdl[i]) mdl[i] = 32'h0;
        mdl[IDX_MEMORY_SIZE] = MEMORY_SIZE_BYTES;
        foreach (RW_SET[i]) r(RW_SET[i]);
        foreach (RW_SET[i]) begin
            w(RW_SET[i], $random(seed));
            r(RW_SET[i]);
        end
        apb(1'b1, 6'h3F, 32'hFFFF_FFFF);
        chk({31'h0, er}, 32'h1);
        apb(1'b0, 6'h3F, 32'h0);
        chk(rd, 32'h0);
        w(IDX_FETCH_THREAD, $random(seed));
        w(IDX_FETCH_REGISTER, $random(seed));
        w(IDX_THREAD_HALT_MASK, $random(seed) | 32'h81);
        repeat (2) @(negedge pclk);
        chk({19'h0, fetch_register, fetch_thread}, {19'h0, mdl[8'h14][4:0], mdl[8'h13][7:0]});
        chk({24'h0, thread_halt}, mdl[IDX_THREAD_HALT_MASK]);
        @(posedge pclk);
        in_debug_mode <= 1'b1;
        repeat (2) @(negedge pclk);
        chk({24'h0, thread_halt}, 32'h0);
        @(posedge pclk);
        in_debug_mode <= 1'b0;
        v = $random(seed);
        core.enter(v, ~v, {v[15:0], v[31:16]});
        mdl[IDX_STATUS_WORD] = v & {21'h0, STATUS_CAPTURE_MASK};
        mdl[IDX_PROGRAM_COUNTER] = ~v;
        mdl[IDX_STACK_POINTER] = {v[15:0], v[31:16]};
        mdl[IDX_EVENT_STATUS][EVENT_ENTRY_BIT] = 1'b1;
        for (int i = 0; i < 3; i++) r(6'(IDX_STATUS_WORD + i));
        for (int c = 1; c < 6; c++) begin
            v = $random(seed);
            v[11] = 1'b1;
            p = 0;
            while (!v[8 + p]) p++;
            core.report(3'(c), v[7:0], v[11:8], ~v);
            mdl[IDX_HALT_CAUSE] = {14'h0, (c > 2) ? 2'(p) : 2'h0,
                (c == 1) ? 8'h0 : v[7:0], 5'h0, 3'(c)};
            if (c > 3) mdl[IDX_HALT_CAUSE_DATA] = ~v;
            mdl[IDX_EVENT_STATUS][EVENT_CAUSE_BIT] = 1'b1;
            r(IDX_HALT_CAUSE);
            r(IDX_HALT_CAUSE_DATA);
        end
        // A report while the clock enable is low must leave every record frozen.
        clk_en <= 1'b0;
        core.report(CAUSE_CALL, 8'h5A, 4'h1, 32'h0);
        clk_en <= 1'b1;
        r(IDX_HALT_CAUSE);
        w(IDX_EVENT_MASK, 32'h4);
        @(negedge pclk);
        chk({31'h0, irq}, 32'h0);
        w(IDX_EVENT_MASK, 32'h7);
        @(negedge pclk);
        chk({31'h0, irq}, 32'h1);
        w(IDX_EVENT_STATUS, 32'h7);
        @(negedge pclk);
        chk({31'h0, irq}, 32'h0);
        for (int k = 0; k < 5; k++) begin
            v = $random(seed);
            w(6'(IDX_BREAK_BASE + k % 4), v);
            w(IDX_BREAK_ENABLE, (k < 4) ? 32'(1 << k) : 32'h0);
            @(posedge pclk);
            {pc_valid, thread_pc} <= {1'b1, v};
            @(posedge pclk);
            pc_valid <= 1'b0;
            @(negedge pclk);
            chk({28'h0, ibreak_hit}, mdl[IDX_BREAK_ENABLE]);
        end
        mdl[IDX_EVENT_STATUS][EVENT_BREAK_BIT] = 1'b1;
        r(IDX_EVENT_STATUS);
        v = $random(seed);
        @(posedge pclk);
        {cfg_scratch_we, cfg_scratch_idx, cfg_scratch_wdata} <= {1'b1, 3'h5, v};
        @(posedge pclk);
        cfg_scratch_we <= 1'b0;
        mdl[IDX_SCRATCH_BASE + 5] = v;
        r(6'(IDX_SCRATCH_BASE + 5));
        @(posedge pclk);
        cfg_scratch_idx <= 3'h2;
        w(6'(IDX_SCRATCH_BASE + 2), ~v);
        repeat (2) @(negedge pclk);
        chk(cfg_scratch_rdata, ~v);
        repeat (2) @(posedge pclk);
        wrap_up();
    end
endmodule : testbench
